// [bench/cpu_core_state_registers_assertions.sv]
`timescale 1ns/10ps
`default_nettype none
module core_state_checker (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic clk_en,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Datapath
	input wire core_state_pkg::alu_result_t alu_res,
	input wire logic push_req,
	input wire logic push_busy,
	input wire core_state_pkg::ram_write_t ram_wr,
	// State views
	input wire logic [7:0] alu_main_operand,
	input wire logic [7:0] cpu_status_word,
	input wire logic [1:0] bank_select,
	input wire logic [7:0] bank_base,
	input wire logic [7:0] stack_top,
	input wire logic info_area_read_sel
);
	import core_state_pkg::*;
	// One clock domain, so clocking and reset are stated once
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);
	// Parity is live, so it must track the operand in every cycle
	AST_PARITY: assert property (cpu_status_word[0] == ^alu_main_operand)
		else $error("parity bit wrong");
	AST_BANK: assert property (bank_select == cpu_status_word[4:3] &&
		bank_base == {3'h0, cpu_status_word[4:3], 3'h0}) else $error("bank base wrong");
	AST_RD_IDLE: assert property (clk_en && !reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not idle");
	AST_SEL_WR: assert property (reg_wr && reg_addr == 4'h6 |=>
		{3'h0, info_area_read_sel, 4'h0} == ($past(reg_wdata) & 8'h10)) else $error("sel write");
	AST_SEL_RD: assert property (reg_rd && reg_addr == 4'h6 |=> reg_rdata[7:5] == 3'h0 &&
		reg_rdata[3:1] == 3'h0 && reg_rdata[4] == info_area_read_sel) else $error("sel read");
	AST_STATUS_WR: assert property (reg_wr && reg_addr == 4'h2 && !alu_res.we |=>
		(cpu_status_word & 8'hFE) == ($past(reg_wdata) & 8'hFE)) else $error("status write");
	AST_ALU: assert property (alu_res.we |=> $past(alu_res) == {1'b1, alu_main_operand,
		cpu_status_word[7], cpu_status_word[6], cpu_status_word[2]}) else $error("alu update");
	AST_PUSH: assert property (push_req && !push_busy |-> ##2 ram_wr.we &&
		ram_wr.addr == $past(stack_top, 2) + 8'h01 ##1 ram_wr.we &&
		ram_wr.addr == $past(stack_top, 3) + 8'h02) else $error("push order wrong");
endmodule
bind cpu_core_state_registers core_state_checker i_core_state_checker (
	.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.alu_res(alu_res), .push_req(push_req), .push_busy(push_busy), .ram_wr(ram_wr),
	.alu_main_operand(alu_main_operand), .cpu_status_word(cpu_status_word),
	.bank_select(bank_select), .bank_base(bank_base), .stack_top(stack_top),
	.info_area_read_sel(info_area_read_sel));
`default_nettype wire

// [bench/cpu_core_state_registers_bench.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module cpu_core_state_registers_bench;
	import core_state_pkg::*;
	logic ref_clk, resetn, reg_wr, reg_rd, push_req, info_area_read_sel;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, stack_top, bank_base;
	logic [15:0] data_ptr_active;
	logic clk_en, alt_boot_en, fetch_load, fetch_step;
	logic [15:0] fetch_target, fetch_counter;
	logic [7:0] aux_operand;
	alu_result_t alu_res;
	muldiv_result_t md_res;
	ram_write_t ram_wr;
	int mismatches = 0;
	int checks_done = 0;
	int cycles = 0;
	// Alternate vector set to a non-zero value so the boot choice is visible
	cpu_core_state_registers #(.ALT_VECTOR(16'h2400)) i_cpu_core_state_registers (
		.ref_clk(ref_clk), .resetn(resetn),
		.clk_en(clk_en), .alt_boot_en(alt_boot_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .alu_res(alu_res),
		.md_res(md_res), .fetch_load(fetch_load), .fetch_target(fetch_target),
		.fetch_step(fetch_step),
		.push_req(push_req), .push_busy(), .ram_wr(ram_wr), .alu_main_operand(),
		.aux_operand(aux_operand), .fetch_counter(fetch_counter), .cpu_status_word(),
		.bank_select(),
		.bank_base(bank_base), .stack_top(stack_top), .data_ptr_active(data_ptr_active),
		.info_area_read_sel(info_area_read_sel));
	// Clock and hang guard; the tests need about 110 cycles
	always #2.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			mismatches++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Bus cycles: one strobe cycle, read data judged in the cycle after
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 `CHK("reg_rdata", e, reg_rdata)
	endtask
	task automatic alu(input logic [7:0] v, input logic c, input logic h, input logic x);
		@(posedge ref_clk);
		alu_res <= {1'b1, v, c, h, x};
		@(posedge ref_clk);
		alu_res.we <= 1'b0;
	endtask
	// Scenarios
	task automatic t_reset();
		rd(4'h2, 8'h00);
		rd(4'h6, 8'h00);
		rd(4'h3, 8'h07);
		rd(4'h7, 8'h00);
		rd(4'h8, 8'h00);
	endtask
	task automatic t_banks();
		for (int k = 0; k < 4; k++)
		begin
			wr(4'h2, 8'hC7 | 8'(k << 3));
			rd(4'h2, 8'hC6 | 8'(k << 3));
			`CHK("bank_base", 8'(k * 8), bank_base)
		end
	endtask
	task automatic t_alu();
		wr(4'h2, 8'h00);
		alu(8'h03, 1'b0, 1'b1, 1'b0);
		rd(4'h2, 8'h40);
		alu(8'h07, 1'b1, 1'b0, 1'b1);
		rd(4'h2, 8'h85);
		rd(4'h0, 8'h07);
		wr(4'h2, 8'h00);
		rd(4'h2, 8'h01);
	endtask
	task automatic t_muldiv();
		@(posedge ref_clk);
		md_res <= {1'b1, 8'h3C, 8'hA5};
		@(posedge ref_clk);
		md_res.we <= 1'b0;
		rd(4'h0, 8'h3C);
		rd(4'h1, 8'hA5);
		wr(4'h1, 8'h5A);
		rd(4'h1, 8'h5A);
	endtask
	// A write while the enable is low must leave the register untouched
	task automatic t_freeze();
		@(posedge ref_clk);
		clk_en <= 1'b0;
		reg_wr <= 1'b1;
		reg_addr <= 4'h1;
		reg_wdata <= 8'h77;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		clk_en <= 1'b1;
		#1 `CHK("aux_frozen", 8'h5A, aux_operand)
	endtask
	// Mid-run reset with the alternate boot option on
	task automatic t_boot();
		@(posedge ref_clk);
		alt_boot_en <= 1'b1;
		resetn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge ref_clk);
		#1 `CHK("boot_vector", 16'h2400, fetch_counter)
		rd(4'h3, 8'h07);
	endtask
	task automatic t_pointers();
		wr(4'h6, 8'hFF);
		rd(4'h6, 8'h11);
		`CHK("info_sel", 1'b1, info_area_read_sel)
		wr(4'h4, 8'h34);
		wr(4'h5, 8'h12);
		wr(4'h6, 8'h00);
		wr(4'h4, 8'hCD);
		wr(4'h5, 8'hAB);
		#1 `CHK("ptr_first", 16'hABCD, data_ptr_active)
		wr(4'h6, 8'h01);
		#1 `CHK("ptr_second", 16'h1234, data_ptr_active)
		rd(4'h5, 8'h12);
		rd(4'hF, 8'h00);
	endtask
	task automatic t_push();
		wr(4'h3, 8'h30);
		// Distinct return bytes so a swapped push order shows
		@(posedge ref_clk);
		fetch_target <= 16'hBE5A;
		fetch_load <= 1'b1;
		@(posedge ref_clk);
		fetch_load <= 1'b0;
		fetch_step <= 1'b1;
		@(posedge ref_clk);
		fetch_step <= 1'b0;
		push_req <= 1'b1;
		#1 `CHK("fetch_counter", 16'hBE5B, fetch_counter)
		@(posedge ref_clk);
		push_req <= 1'b0;
		@(posedge ref_clk);
		#1 `CHK("push_low", 17'h1315B, ram_wr)
		@(posedge ref_clk);
		#1 `CHK("push_high", 17'h132BE, ram_wr)
		rd(4'h3, 8'h32);
		rd(4'h7, 8'h5B);
		rd(4'h8, 8'hBE);
	endtask
	// Reset for ten cycles, then wait out the reset synchroniser
	initial
	begin
		ref_clk = 1'b0;
		resetn = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		push_req = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		alu_res = '0;
		md_res = '0;
		clk_en = 1'b1;
		alt_boot_en = 1'b0;
		fetch_load = 1'b0;
		fetch_step = 1'b0;
		fetch_target = 16'h0000;
		repeat (10) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge ref_clk);
		t_reset();
		t_banks();
		t_alu();
		t_muldiv();
		t_freeze();
		t_pointers();
		t_push();
		t_boot();
		report_and_stop();
	end
endmodule
`default_nettype wire

// [rtl/core_state_defs.svh]
// Summary of operation
// - Fetch counter is 16 bits and loads zero on reset.
// - With the alternate boot option set, the first enabled cycle after reset loads the alternate vector instead.
// - The main operand register feeds the ALU and takes arithmetic results.
// - Auxiliary register takes multiply/divide operands and results, else general purpose.
// - Status bit 7 follows the carry or borrow of arithmetic.
// - Status bit 6 follows the nibble carry or borrow of arithmetic.
// - Status bits 4-3 pick the working bank at RAM 00H, 08H, 10H or 18H.
// - Status bit 2 follows arithmetic overflow.
// - Status bit 0 is read-only even parity of the main operand register.
// - Stack top is 8 bits and resets to 07H.
// - Calls and interrupts pre-increment and push return low byte, then high byte.
// - Two 16-bit data pointers share addresses; only the selected one is reached.
// - Select bit 0 picks the data pointer, read/write, reset zero.
// - Select bit 4 steers table reads to program area (0) or option area (1).
// - Select bits 7-5 and 3-1 read zero and ignore writes.
`ifndef CORE_STATE_DEFS_SVH
`define CORE_STATE_DEFS_SVH
`define ADDR_MAIN_OPERAND 4'h0
`define ADDR_AUX_OPERAND 4'h1
`define ADDR_STATUS 4'h2
`define ADDR_STACK_TOP 4'h3
`define ADDR_PTR_LOW 4'h4
`define ADDR_PTR_HIGH 4'h5
`define ADDR_PTR_SELECT 4'h6
`define ADDR_FETCH_LOW 4'h7
`define ADDR_FETCH_HIGH 4'h8
`define STATUS_RESET 8'h00
`define STATUS_WR_MASK 8'hFE
`define SELECT_RESET 8'h00
`define SELECT_WR_MASK 8'h11
`define STACK_RESET 8'h07
`define FETCH_RESET 16'h0000
`define BIT_CARRY 7
`define BIT_HALF 6
`define BIT_BANK_HI 4
`define BIT_BANK_LO 3
`define BIT_EXCESS 2
`define BIT_CHOICE 0
`define BIT_INFO_SEL 4
`endif

// [rtl/core_state_pkg.sv]
package core_state_pkg;
	// Arithmetic result with its flags, as the datapath delivers it
	typedef struct packed {
		logic we;
		logic [7:0] value;
		logic carry;
		logic half;
		logic excess;
	} alu_result_t;
	// Multiply/divide result pair
	typedef struct packed {
		logic we;
		logic [7:0] main_val;
		logic [7:0] aux_val;
	} muldiv_result_t;
	// Stack push port towards internal RAM
	typedef struct packed {
		logic we;
		logic [7:0] addr;
		logic [7:0] data;
	} ram_write_t;
	typedef enum logic [1:0] {push_idle, push_low, push_high} push_state_t;
endpackage

// [rtl/cpu_core_state_registers.sv]
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "core_state_defs.svh"
module cpu_core_state_registers #(
	parameter logic [15:0] ALT_VECTOR = 16'h0000
)(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic clk_en,
	// Boot option
	input wire logic alt_boot_en,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Datapath
	input wire core_state_pkg::alu_result_t alu_res,
	input wire core_state_pkg::muldiv_result_t md_res,
	input wire logic fetch_load,
	input wire logic [15:0] fetch_target,
	input wire logic fetch_step,
	input wire logic push_req,
	output logic push_busy,
	output core_state_pkg::ram_write_t ram_wr,
	// State views
	output logic [7:0] alu_main_operand,
	output logic [7:0] aux_operand,
	output logic [15:0] fetch_counter,
	output logic [7:0] cpu_status_word,
	output logic [1:0] bank_select,
	output logic [7:0] bank_base,
	output logic [7:0] stack_top,
	output logic [15:0] data_ptr_active,
	output logic info_area_read_sel
);
	import core_state_pkg::*;

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	logic rst_sync1_ff, rst_sync2_ff;
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rst_sync1_ff <= 1'b0;
			rst_sync2_ff <= 1'b0;
		end
		else
		begin
			rst_sync1_ff <= 1'b1;
			rst_sync2_ff <= rst_sync1_ff;
		end
	end
	wire rst_n = rst_sync2_ff;

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [7:0] main_ff, aux_ff, flags_ff, sp_ff, select_ff, rd_ff;
	logic [15:0] pc_ff, ptr_first_ff, ptr_second_ff;
	logic boot_pending_ff;
	push_state_t push_ff;
	ram_write_t ram_ff;
	logic [15:0] ret_ff;
	wire wr_hit = reg_wr && clk_en;
	wire choice = select_ff[`BIT_CHOICE];

	// Main operand: datapath results win over software in the same cycle
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			main_ff <= 8'h00;
		else if (clk_en)
		begin
			if (md_res.we)
				main_ff <= md_res.main_val;
			else if (alu_res.we)
				main_ff <= alu_res.value;
			else if (reg_wr && reg_addr == `ADDR_MAIN_OPERAND)
				main_ff <= reg_wdata;
		end
	end

	// Auxiliary register: general purpose outside multiply/divide
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			aux_ff <= 8'h00;
		else if (clk_en)
		begin
			if (md_res.we)
				aux_ff <= md_res.aux_val;
			else if (reg_wr && reg_addr == `ADDR_AUX_OPERAND)
				aux_ff <= reg_wdata;
		end
	end

	// Status flags; bit 0 is never stored, parity is computed live
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			flags_ff <= `STATUS_RESET;
		else if (clk_en)
		begin
			if (reg_wr && reg_addr == `ADDR_STATUS)
				flags_ff <= reg_wdata & `STATUS_WR_MASK;
			if (alu_res.we)
			begin
				flags_ff[`BIT_CARRY] <= alu_res.carry;
				flags_ff[`BIT_HALF] <= alu_res.half;
				flags_ff[`BIT_EXCESS] <= alu_res.excess;
			end
		end
	end
	wire parity = ^main_ff;

	// Fetch counter; the boot vector is chosen in the first enabled cycle after reset
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pc_ff <= `FETCH_RESET;
			boot_pending_ff <= 1'b1;
		end
		else if (clk_en)
		begin
			boot_pending_ff <= 1'b0;
			if (boot_pending_ff)
				pc_ff <= alt_boot_en ? ALT_VECTOR : `FETCH_RESET;
			else if (fetch_load)
				pc_ff <= fetch_target;
			else if (fetch_step)
				pc_ff <= pc_ff + 16'h0001;
		end
	end

	// Stack push sequencer: low byte then high byte, each after a pre-increment
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			push_ff <= push_idle;
			sp_ff <= `STACK_RESET;
			ram_ff <= '0;
			ret_ff <= 16'h0000;
		end
		else if (clk_en)
		begin
			ram_ff.we <= 1'b0;
			case (push_ff)
				push_idle:
				begin
					if (push_req)
					begin
						ret_ff <= pc_ff;
						push_ff <= push_low;
					end
					else if (reg_wr && reg_addr == `ADDR_STACK_TOP)
						sp_ff <= reg_wdata;
				end
				push_low:
				begin
					sp_ff <= sp_ff + 8'h01;
					ram_ff <= '{we: 1'b1, addr: sp_ff + 8'h01, data: ret_ff[7:0]};
					push_ff <= push_high;
				end
				push_high:
				begin
					sp_ff <= sp_ff + 8'h01;
					ram_ff <= '{we: 1'b1, addr: sp_ff + 8'h01, data: ret_ff[15:8]};
					push_ff <= push_idle;
				end
				default: push_ff <= push_idle;
			endcase
		end
	end

	// Data pointers: one address pair, steered by the choice bit
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ptr_first_ff <= 16'h0000;
			ptr_second_ff <= 16'h0000;
		end
		else if (wr_hit)
		begin
			if (reg_addr == `ADDR_PTR_LOW && !choice)
				ptr_first_ff[7:0] <= reg_wdata;
			if (reg_addr == `ADDR_PTR_HIGH && !choice)
				ptr_first_ff[15:8] <= reg_wdata;
			if (reg_addr == `ADDR_PTR_LOW && choice)
				ptr_second_ff[7:0] <= reg_wdata;
			if (reg_addr == `ADDR_PTR_HIGH && choice)
				ptr_second_ff[15:8] <= reg_wdata;
		end
	end

	// Select register; only two bits exist, the rest read zero
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			select_ff <= `SELECT_RESET;
		else if (wr_hit && reg_addr == `ADDR_PTR_SELECT)
			select_ff <= reg_wdata & `SELECT_WR_MASK;
	end

	// Read data, one cycle after the strobe; unmapped reads return zero
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			rd_ff <= 8'h00;
		else if (clk_en)
		begin
			if (reg_rd)
			begin
				case (reg_addr)
					`ADDR_MAIN_OPERAND: rd_ff <= main_ff;
					`ADDR_AUX_OPERAND: rd_ff <= aux_ff;
					`ADDR_STATUS: rd_ff <= cpu_status_word;
					`ADDR_STACK_TOP: rd_ff <= sp_ff;
					`ADDR_PTR_LOW: rd_ff <= data_ptr_active[7:0];
					`ADDR_PTR_HIGH: rd_ff <= data_ptr_active[15:8];
					`ADDR_PTR_SELECT: rd_ff <= select_ff;
					`ADDR_FETCH_LOW: rd_ff <= pc_ff[7:0];
					`ADDR_FETCH_HIGH: rd_ff <= pc_ff[15:8];
					default: rd_ff <= 8'h00;
				endcase
			end
			else
				rd_ff <= 8'h00;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign reg_rdata = rd_ff;
	assign alu_main_operand = main_ff;
	assign aux_operand = aux_ff;
	assign fetch_counter = pc_ff;
	assign cpu_status_word = {flags_ff[7:1], parity};
	assign bank_select = flags_ff[`BIT_BANK_HI:`BIT_BANK_LO];
	assign bank_base = {3'b000, bank_select, 3'b000};
	assign stack_top = sp_ff;
	assign data_ptr_active = choice ? ptr_second_ff : ptr_first_ff;
	assign info_area_read_sel = select_ff[`BIT_INFO_SEL];
	assign push_busy = (push_ff != push_idle);
	assign ram_wr = ram_ff;
endmodule
`default_nettype wire
